// ---- verilog/lcis_pkg.sv ----
//==========================================================
// register map
package lcis_pkg;

	localparam int              ADDR_W      = 12;
	localparam logic [11:0]     CTRL_OFFSET = 12'h000;
	localparam logic [11:0]     SEL_OFFSET  = 12'h004;
	localparam logic [11:0]     GATE_OFFSET = 12'h008;

	// writable bits; everything else reads zero, except status bit 6 of the control word
	localparam logic [31:0]     CTRL_MASK   = 32'h000F_80A7;
	localparam logic [31:0]     SEL_MASK    = 32'h0000_7777;
	localparam logic [31:0]     GATE_MASK   = 32'hFFFF_FFFF;

	localparam logic [31:0]     CTRL_RESET  = 32'h0000_0000;
	localparam logic [31:0]     SEL_RESET   = 32'h0000_0000;
	localparam logic [31:0]     GATE_RESET  = 32'h0000_0000;

	//==========================================================
	// field positions
	localparam int              MODE_LSB    = 0;
	localparam int              LCPOL_BIT   = 5;
	localparam int              CELL_OUTPUT_STATUS_BIT   = 6;
	localparam int              LCOE_BIT    = 7;
	localparam int              ON_BIT      = 15;
	localparam int              GPOL_LSB    = 16;
	localparam int              DS_W        = 3;
	localparam int              DS1_LSB     = 0;
	localparam int              DS2_LSB     = 4;
	localparam int              DS3_LSB     = 8;
	localparam int              DS4_LSB     = 12;
	localparam int              GATE_BYTE_W = 8;
	localparam int              NUM_GATES   = 4;

	//==========================================================
	// cell function modes
	typedef enum logic [2:0] {
		MODE_AND_OR  = 3'b000,
		MODE_OR_XOR  = 3'b001,
		MODE_AND4    = 3'b010,
		MODE_SR      = 3'b011,
		MODE_DFF_SR  = 3'b100,
		MODE_DFF2_R  = 3'b101,
		MODE_JK_R    = 3'b110,
		MODE_LATCH   = 3'b111
	} lcis_mode_type;

endpackage

// ---- verilog/lcis_gate.sv ----
`timescale 1ns/1ps

//==========================================================
// one gate: or of enabled true/inverted sources, then polarity
module lcis_gate (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] data_src,
	input  wire logic [7:0] enables,
	input  wire logic       polarity,
	output logic            gate_out
);

	logic [3:0] true_terms;
	logic [3:0] inv_terms;
	logic       raw_or;

	// odd bit of each pair is true, even bit inverted
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_term
			assign true_terms[k] = enables[2*k+1] & data_src[k];
			assign inv_terms[k]  = enables[2*k] & ~data_src[k];
		end
	endgenerate

	// empty enable set gives a zero or-term; the gate then equals its polarity bit
	assign raw_or   = |{true_terms, inv_terms};
	assign gate_out = raw_or ^ polarity;

	//==========================================================
	// checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	top_pair_a: assert property (enables == 8'h80 |-> raw_or == data_src[3])
		else $error("source 4 true enable not in bit 7");
	true_pass_a: assert property (enables == 8'h02 |-> raw_or == data_src[0])
		else $error("true enable does not pass source");
	inv_pass_a: assert property (enables == 8'h01 |-> raw_or == !data_src[0])
		else $error("inverted enable does not complement source");
	empty_gate_a: assert property (enables == 8'h00 |-> !raw_or)
		else $error("gate with no enables not zero");
	gate_pol_a: assert property (polarity |-> gate_out != raw_or)
		else $error("gate polarity not applied");

endmodule

// ---- verilog/lcis_cell.sv ----
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps

// Summary of operation
// - cell 1 selector one: pin B, cell 2, unit 5 out, serial 1, comparator_three, calendar...
// - cell 2 selector one: pin B, cell 1, unit 5 second out, serial 2, same rest.
// - cell 3 selector one: pin B, cell 4, unit 7 out, serial 3, multi unit 2.
// - cell 4 selector one: like cell 3, multi unit 3, code 011 reserved.
// - cell 3 selector two: pin A, own, comparator_two, serial_port3_data_out, rx3, unit 6 out/match, unit 7.
// - cell 4 selector two: like cell 3, codes 011 and 100 reserved.
// - gate register: one byte per gate, source pairs low to high, true above inverted.
// - true enable set feeds the selected source unchanged into the gate.
// - inverted enable set feeds the complement of the source into the gate.
// - gate polarity bit set inverts that gate before the cell function.
// - 3-bit mode picks one of eight cell functions.
// - cell disabled drives zero on cell_out and cell_port_out; enabled it combines its inputs.
module lcis_cell #(
	parameter int CELL_INDEX = 1
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic [lcis_pkg::ADDR_W-1:0] paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        cell_pin_input_a,
	input  wire logic                        cell_pin_input_b,
	input  wire logic                        peer_cell_out,
	input  wire logic                        capture_a_out,
	input  wire logic                        capture_a_match,
	input  wire logic                        capture_b_out,
	input  wire logic                        capture_b_match,
	input  wire logic                        multi_capture_match,
	input  wire logic                        comparator_one,
	input  wire logic                        comparator_two,
	input  wire logic                        comparator_three,
	input  wire logic                        calendar_clock_event,
	input  wire logic                        serial_data_in,
	input  wire logic                        serial_data_out,
	input  wire logic                        serial_rx_in,
	input  wire logic                        uart_tx_out,
	input  wire logic                        adc_conversion_done,
	input  wire logic                        dma_channel_irq,
	output logic                             cell_out,
	output logic                             cell_port_out,
	output logic                             cell_port_oe
);

	localparam int  ASYNC_N = 17;
	localparam logic NO_SERIAL = (CELL_INDEX == 4);

	//==========================================================
	// input synchronisers
	logic [ASYNC_N-1:0] async_raw;
	logic [ASYNC_N-1:0] sync1_ff;
	logic [ASYNC_N-1:0] sync2_ff;

	assign async_raw = {dma_channel_irq, adc_conversion_done, uart_tx_out, serial_rx_in,
		serial_data_out, serial_data_in, calendar_clock_event, comparator_three,
		comparator_two, comparator_one, multi_capture_match, capture_b_match,
		capture_b_out, capture_a_match, capture_a_out, cell_pin_input_b,
		cell_pin_input_a};

	// peer cell shares pclk, so only the foreign sources are synchronised
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= async_raw;
			sync2_ff <= sync1_ff;
		end
	end

	logic pin_a_s, pin_b_s, cap_a_out_s, cap_a_match_s, cap_b_out_s, cap_b_match_s;
	logic mc_match_s, cmp1_s, comparator_two_s, comparator_three_s, cal_s, sdi_s, sdo_s, rx_s, tx_s, adc_s, dma_s;

	assign {dma_s, adc_s, tx_s, rx_s, sdo_s, sdi_s, cal_s, comparator_three_s, comparator_two_s, cmp1_s,
		mc_match_s, cap_b_match_s, cap_b_out_s, cap_a_match_s, cap_a_out_s,
		pin_b_s, pin_a_s} = sync2_ff;

	//==========================================================
	// registers
	logic [31:0] ctrl_ff;
	logic [31:0] sel_ff;
	logic [31:0] gate_ff;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        cell_out_ff;
	logic        cell_port_out_ff;
	logic        cell_port_oe_ff;

	//==========================================================
	// source selection
	function automatic logic pick8(input logic [2:0] code, input logic [7:0] src);
		return src[code];
	endfunction

	logic [7:0] ds1_vec;
	logic [7:0] ds2_vec;
	logic [7:0] ds3_vec;
	logic [3:0] data_src;

	// reserved codes feed a constant zero
	assign ds1_vec = {cap_a_match_s, mc_match_s, cal_s, comparator_three_s,
		sdi_s & ~NO_SERIAL, cap_a_out_s, peer_cell_out, pin_b_s};
	assign ds2_vec = {cap_a_match_s, cap_b_match_s, cap_b_out_s, rx_s & ~NO_SERIAL,
		sdo_s & ~NO_SERIAL, comparator_two_s, cell_out_ff, pin_a_s};
	assign ds3_vec = {1'b0, mc_match_s, dma_s, adc_s, tx_s & ~NO_SERIAL,
		cmp1_s, peer_cell_out, pin_b_s};

	// fourth selector offers the same sources as the first
	assign data_src[0] = pick8(sel_ff[lcis_pkg::DS1_LSB +: lcis_pkg::DS_W], ds1_vec);
	assign data_src[1] = pick8(sel_ff[lcis_pkg::DS2_LSB +: lcis_pkg::DS_W], ds2_vec);
	assign data_src[2] = pick8(sel_ff[lcis_pkg::DS3_LSB +: lcis_pkg::DS_W], ds3_vec);
	assign data_src[3] = pick8(sel_ff[lcis_pkg::DS4_LSB +: lcis_pkg::DS_W], ds1_vec);

	//==========================================================
	// gates
	logic [3:0] gate_v;

	genvar g;
	generate
		for (g = 0; g < lcis_pkg::NUM_GATES; g++) begin : g_gate
			lcis_gate u_gate (
				.pclk     (pclk),
				.presetn  (presetn),
				.data_src (data_src),
				.enables  (gate_ff[g*lcis_pkg::GATE_BYTE_W +: lcis_pkg::GATE_BYTE_W]),
				.polarity (ctrl_ff[lcis_pkg::GPOL_LSB+g]),
				.gate_out (gate_v[g])
			);
		end
	endgenerate

	//==========================================================
	// cell function
	lcis_pkg::lcis_mode_type mode;
	logic                    cell_on;
	logic                    q_ff;
	logic                    g1_prev_ff;
	logic                    nxt_q;
	logic                    result;
	logic                    clk_rise;

	assign mode     = lcis_pkg::lcis_mode_type'(ctrl_ff[lcis_pkg::MODE_LSB +: 3]);
	assign cell_on  = ctrl_ff[lcis_pkg::ON_BIT];
	assign clk_rise = gate_v[0] & ~g1_prev_ff;

	// gate 1 is the clock of flop modes, gate 3 reset; gate 4 sets in MODE_DFF_SR and the latch
	always_comb begin
		nxt_q  = q_ff;
		result = 1'b0;
		case (mode)
			lcis_pkg::MODE_AND_OR: result = (gate_v[0] & gate_v[1]) | (gate_v[2] & gate_v[3]);
			lcis_pkg::MODE_OR_XOR: result = (gate_v[0] | gate_v[1]) ^ (gate_v[2] | gate_v[3]);
			lcis_pkg::MODE_AND4:   result = &gate_v;
			lcis_pkg::MODE_SR: begin
				if (gate_v[0] | gate_v[1]) nxt_q = 1'b1;
				else if (gate_v[2] | gate_v[3]) nxt_q = 1'b0;
				result = nxt_q;
			end
			lcis_pkg::MODE_DFF_SR: begin
				if (gate_v[2]) nxt_q = 1'b0;
				else if (gate_v[3]) nxt_q = 1'b1;
				else if (clk_rise) nxt_q = gate_v[1];
				result = nxt_q;
			end
			lcis_pkg::MODE_DFF2_R: begin
				if (gate_v[2]) nxt_q = 1'b0;
				else if (clk_rise) nxt_q = gate_v[1] & gate_v[3];
				result = nxt_q;
			end
			lcis_pkg::MODE_JK_R: begin
				if (gate_v[2]) nxt_q = 1'b0;
				else if (clk_rise) nxt_q = (gate_v[1] & ~q_ff) | (~gate_v[3] & q_ff);
				result = nxt_q;
			end
			default: begin
				if (gate_v[2]) nxt_q = 1'b0;
				else if (gate_v[3]) nxt_q = 1'b1;
				else if (gate_v[0]) nxt_q = gate_v[1];
				result = nxt_q;
			end
		endcase
	end

	// state cleared while off so a re-enable starts from zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_ff       <= 1'b0;
			g1_prev_ff <= 1'b0;
		end else begin
			q_ff       <= cell_on & nxt_q;
			g1_prev_ff <= gate_v[0];
		end
	end

	// outputs registered; one pclk of latency from the synced sources
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cell_out_ff      <= 1'b0;
			cell_port_out_ff <= 1'b0;
			cell_port_oe_ff  <= 1'b0;
		end else begin
			cell_out_ff      <= cell_on & (result ^ ctrl_ff[lcis_pkg::LCPOL_BIT]);
			cell_port_out_ff <= cell_on & (result ^ ctrl_ff[lcis_pkg::LCPOL_BIT]);
			cell_port_oe_ff  <= ctrl_ff[lcis_pkg::LCOE_BIT];
		end
	end

	//==========================================================
	// apb slave: one wait-free access phase
	logic        setup_ph;
	logic        access_ph;
	logic        addr_hit;
	logic [31:0] rd_val;

	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable & pready_ff;

	// address decode; status bit merged into the control word
	always_comb begin
		addr_hit = 1'b1;
		rd_val   = 32'h0000_0000;
		if (paddr == lcis_pkg::CTRL_OFFSET) begin
			rd_val = ctrl_ff;
			rd_val[lcis_pkg::CELL_OUTPUT_STATUS_BIT] = cell_out_ff;
		end else if (paddr == lcis_pkg::SEL_OFFSET) begin
			rd_val = sel_ff;
		end else if (paddr == lcis_pkg::GATE_OFFSET) begin
			rd_val = gate_ff;
		end else begin
			addr_hit = 1'b0;
		end
	end

	// answer prepared in the setup cycle, shown in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= setup_ph;
			pslverr_ff <= setup_ph & ~addr_hit;
			if (setup_ph) prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
		end
	end

	// writes land at the access edge; masks keep unused bits zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= lcis_pkg::CTRL_RESET;
			sel_ff  <= lcis_pkg::SEL_RESET;
			gate_ff <= lcis_pkg::GATE_RESET;
		end else if (access_ph && pwrite) begin
			if (paddr == lcis_pkg::CTRL_OFFSET) ctrl_ff <= pwdata & lcis_pkg::CTRL_MASK;
			else if (paddr == lcis_pkg::SEL_OFFSET) sel_ff <= pwdata & lcis_pkg::SEL_MASK;
			else if (paddr == lcis_pkg::GATE_OFFSET) gate_ff <= pwdata & lcis_pkg::GATE_MASK;
		end
	end

	assign prdata        = prdata_ff;
	assign pready        = pready_ff;
	assign pslverr       = pslverr_ff;
	assign cell_out      = cell_out_ff;
	assign cell_port_out = cell_port_out_ff;
	assign cell_port_oe  = cell_port_oe_ff;

	//==========================================================
	// checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sel_write_a: assert property (
		access_ph && pwrite && paddr == lcis_pkg::SEL_OFFSET
		|=> sel_ff == ($past(pwdata) & 32'h0000_7777))
		else $error("selector write not masked or not stored");
	cell_off_a: assert property (!cell_on |=> !cell_out_ff && !cell_port_out_ff)
		else $error("disabled cell drives a one");
	and4_mode_a: assert property (
		cell_on && mode == lcis_pkg::MODE_AND4 && !ctrl_ff[lcis_pkg::LCPOL_BIT]
		|=> cell_out_ff == $past(&gate_v))
		else $error("four-input and mode wrong");
	cell1_peer_a: assert property (
		CELL_INDEX == 1 && sel_ff[2:0] == 3'h1 |-> data_src[0] == peer_cell_out)
		else $error("cell 1 selector one code 1 wrong");
	cell2_serial_a: assert property (
		CELL_INDEX == 2 && sel_ff[2:0] == 3'h3 |-> data_src[0] == sdi_s)
		else $error("cell 2 selector one code 3 wrong");
	cell3_multi_a: assert property (
		CELL_INDEX == 3 && sel_ff[2:0] == 3'h6 |-> data_src[0] == mc_match_s)
		else $error("cell 3 selector one code 6 wrong");
	cell4_resv_a: assert property (
		CELL_INDEX == 4 && sel_ff[2:0] == 3'h3 |-> !data_src[0])
		else $error("cell 4 reserved code not zero");
	cell3_rx_a: assert property (
		CELL_INDEX == 3 && sel_ff[6:4] == 3'h4 |-> data_src[1] == rx_s)
		else $error("cell 3 selector two code 4 wrong");
	cell4_ds2_a: assert property (
		CELL_INDEX == 4 && (sel_ff[6:4] == 3'h3 || sel_ff[6:4] == 3'h4) |-> !data_src[1])
		else $error("cell 4 selector two reserved code not zero");
	apb_ready_a: assert property (setup_ph |=> pready_ff ##1 !pready_ff)
		else $error("apb ready not a single access cycle");

endmodule

// ---- verification/lcis_src_model.sv ----
`timescale 1ns/1ps

//==========================================================
// peripheral source bank for one logic cell
// bit order: 0 pin a, 1 pin b, 2 peer cell, 3 unit 7 out, 4 unit 7 match,
// 5 unit 6 out, 6 unit 6 match, 7 multi match, 8..10 comparators 1..3,
// 11 calendar, 12 serial in, 13 serial out, 14 rx in, 15 tx, 16 adc, 17 dma
module lcis_src_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [17:0] src_cmd,
	output logic      [17:0] src_lvl_ff
);
	// levels move only just after an edge, as real peripheral flops do
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_lvl_ff <= 18'h0;
		end else begin
			src_lvl_ff <= src_cmd;
		end
	end
endmodule

// ---- verification/tb_logic_cell_input_select.sv ----
`timescale 1ns/1ps

//==========================================================
// bench for cell 3: selectors, gate enables, polarity, register map
module tb_logic_cell_input_select;
	logic        pclk     = 1'b0;
	logic        presetn  = 1'b0;
	logic [11:0] paddr    = 12'h000;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [31:0] pwdata   = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cell_out;
	logic        cell_port_out;
	logic        cell_port_oe;
	logic [17:0] src_cmd  = 18'h0;
	logic [17:0] src;
	logic [31:0] rng      = 32'h8E31;
	logic [44:0] notes[$];
	logic [44:0] nt;
	logic [31:0] ctrl;
	logic [3:0]  e;
	logic [3:0]  gpol;
	logic        p;
	logic        lp;
	logic        gv;
	logic        q;
	logic        r;
	logic        g1p;
	int          idx;
	int          n_errors        = 0;
	int          samples_checked = 0;
	// source index per code for cell 3; selector two code 1 is own output
	int          ds1_map[8]      = '{1, 2, 3, 12, 10, 11, 7, 4};
	int          ds2_map[8]      = '{0, 0, 9, 13, 14, 5, 6, 4};

	always #2.5 pclk = ~pclk;

	lcis_src_model src_u (
		.pclk       (pclk),
		.presetn    (presetn),
		.src_cmd    (src_cmd),
		.src_lvl_ff (src)
	);

	lcis_cell #(.CELL_INDEX(3)) dut_u (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cell_pin_input_a(src[0]),
		.cell_pin_input_b(src[1]), .peer_cell_out(src[2]), .capture_a_out(src[3]),
		.capture_a_match(src[4]), .capture_b_out(src[5]), .capture_b_match(src[6]),
		.multi_capture_match(src[7]), .comparator_one(src[8]),
		.comparator_two(src[9]), .comparator_three(src[10]),
		.calendar_clock_event(src[11]), .serial_data_in(src[12]),
		.serial_data_out(src[13]), .serial_rx_in(src[14]), .uart_tx_out(src[15]),
		.adc_conversion_done(src[16]), .dma_channel_irq(src[17]),
		.cell_out(cell_out), .cell_port_out(cell_port_out),
		.cell_port_oe(cell_port_oe)
	);

	// cells 1, 2 and 4 share bus and sources; their own checks watch the selectors
	for (genvar k = 1; k <= 4; k++) begin : g_side
		if (k != 3) begin : g_on
			lcis_cell #(.CELL_INDEX(k)) side_u (
				.pclk(pclk), .presetn(presetn), .paddr(paddr),
				.psel(psel), .penable(penable), .pwrite(pwrite),
				.pwdata(pwdata), .prdata(), .pready(), .pslverr(),
				.cell_pin_input_a(src[0]), .cell_pin_input_b(src[1]),
				.peer_cell_out(src[2]), .capture_a_out(src[3]),
				.capture_a_match(src[4]), .capture_b_out(src[5]),
				.capture_b_match(src[6]), .multi_capture_match(src[7]),
				.comparator_one(src[8]), .comparator_two(src[9]),
				.comparator_three(src[10]), .calendar_clock_event(src[11]),
				.serial_data_in(src[12]), .serial_data_out(src[13]),
				.serial_rx_in(src[14]), .uart_tx_out(src[15]),
				.adc_conversion_done(src[16]), .dma_channel_irq(src[17]),
				.cell_out(), .cell_port_out(), .cell_port_oe()
			);
		end
	end

	//==========================================================
	// helpers
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// note the expectation first so the monitor finds it at the answer edge
	task automatic rd(input logic [11:0] a, input logic err, input logic [31:0] d);
		notes.push_back({a, err, d});
		apb(1'b0, a, 32'h0);
	endtask

	//==========================================================
	// monitor: oldest note against each read answer
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			nt = notes.pop_front();
			check(prdata, nt[31:0]);
			check({31'h0, pslverr}, {31'h0, nt[32]});
			if (nt[44:33] == lcis_pkg::CTRL_OFFSET) begin
				check({31'h0, cell_out}, {31'h0, nt[6]});
				check({31'h0, cell_port_out}, {31'h0, nt[6]});
				check({31'h0, cell_port_oe}, {31'h0, nt[7]});
			end
		end
	end

	// watchdog: the whole run needs under two thousand cycles
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		tally_and_finish();
	end

	//==========================================================
	// main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(lcis_pkg::CTRL_OFFSET, 1'b0, 32'h0);
		rd(lcis_pkg::SEL_OFFSET, 1'b0, 32'h0);
		rd(lcis_pkg::GATE_OFFSET, 1'b0, 32'h0);
		apb(1'b1, lcis_pkg::SEL_OFFSET, 32'hFFFF_FFFF);
		rd(lcis_pkg::SEL_OFFSET, 1'b0, lcis_pkg::SEL_MASK);
		apb(1'b1, lcis_pkg::GATE_OFFSET, 32'hA5C3_3C5A);
		rd(lcis_pkg::GATE_OFFSET, 1'b0, 32'hA5C3_3C5A);
		apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
		rd(12'h00C, 1'b1, 32'h0);
		$display("test registers done");
		// gates 3 and 4 held high by polarity, gates 1 and 2 follow one source
		apb(1'b1, lcis_pkg::CTRL_OFFSET, 32'h000C_8082);
		for (int ds = 0; ds < 2; ds++) begin
			apb(1'b1, lcis_pkg::GATE_OFFSET, (ds == 1) ? 32'h0000_0808 : 32'h0000_0202);
			for (int c = 0; c < 16; c++) begin
				if (ds == 1 && (c % 8) == 1) continue;
				rng = lfsr_next(lfsr_next(rng));
				src_cmd <= rng[17:0];
				apb(1'b1, lcis_pkg::SEL_OFFSET, (c % 8) << ((ds == 1) ? 4 : 0));
				repeat (6) @(posedge pclk);
				idx = (ds == 1) ? ds2_map[c % 8] : ds1_map[c % 8];
				rd(lcis_pkg::CTRL_OFFSET, 1'b0, {25'h0, rng[idx], 6'h0} | 32'h000C_8082);
			end
		end
		$display("test selectors done");
		// one gate under test in four-input and mode, the rest forced high
		apb(1'b1, lcis_pkg::SEL_OFFSET, 32'h0);
		for (int g = 0; g < 4; g++) begin
			for (int k = 0; k < 6; k++) begin
				rng = lfsr_next(lfsr_next(rng));
				e = rng[3:0];
				p = rng[8];
				lp = rng[9];
				src_cmd <= {16'h0, rng[10], rng[11]};
				gpol = ~(4'b0001 << g) | ({3'b000, p} << g);
				ctrl = {12'h0, gpol, 16'h8082 | {10'h0, lp, 5'h0}};
				apb(1'b1, lcis_pkg::GATE_OFFSET, {28'h0, e} << (8 * g));
				apb(1'b1, lcis_pkg::CTRL_OFFSET, ctrl);
				repeat (6) @(posedge pclk);
				gv = (e[1] & rng[10]) | (e[0] & ~rng[10]) | (e[3] & rng[11]) | (e[2] & ~rng[11]);
				rd(lcis_pkg::CTRL_OFFSET, 1'b0, ctrl | {25'h0, gv ^ p ^ lp, 6'h0});
			end
		end
		// source 4 true enable sits in the top bit of every gate byte
		for (int k = 0; k < 2; k++) begin
			src_cmd <= {16'h0, k[0], 1'b0};
			apb(1'b1, lcis_pkg::GATE_OFFSET, 32'h8080_8080);
			apb(1'b1, lcis_pkg::CTRL_OFFSET, 32'h0000_8082);
			repeat (6) @(posedge pclk);
			rd(lcis_pkg::CTRL_OFFSET, 1'b0, 32'h0000_8082 | {25'h0, k[0], 6'h0});
		end
		$display("test gates done");
		// no enables: each gate equals its polarity bit, so the functions are steered directly
		apb(1'b1, lcis_pkg::GATE_OFFSET, 32'h0);
		q   = 1'b0;
		g1p = 1'b0;
		for (int m = 0; m < 8; m++) begin
			for (int k = 0; k < 8; k++) begin
				rng  = lfsr_next(lfsr_next(rng));
				gpol = rng[3:0];
				ctrl = {12'h0, gpol, 16'h8080 | {13'h0, m[2:0]}};
				apb(1'b1, lcis_pkg::CTRL_OFFSET, ctrl);
				repeat (6) @(posedge pclk);
				case (m)
					0: r = (gpol[0] & gpol[1]) | (gpol[2] & gpol[3]);
					1: r = (gpol[0] | gpol[1]) ^ (gpol[2] | gpol[3]);
					2: r = &gpol;
					3: begin
						if (gpol[0] | gpol[1]) q = 1'b1;
						else if (gpol[2] | gpol[3]) q = 1'b0;
						r = q;
					end
					4: begin
						if (gpol[2]) q = 1'b0;
						else if (gpol[3]) q = 1'b1;
						else if (gpol[0] & ~g1p) q = gpol[1];
						r = q;
					end
					5: begin
						if (gpol[2]) q = 1'b0;
						else if (gpol[0] & ~g1p) q = gpol[1] & gpol[3];
						r = q;
					end
					6: begin
						if (gpol[2]) q = 1'b0;
						else if (gpol[0] & ~g1p) q = (gpol[1] & ~q) | (~gpol[3] & q);
						r = q;
					end
					default: begin
						if (gpol[2]) q = 1'b0;
						else if (gpol[3]) q = 1'b1;
						else if (gpol[0]) q = gpol[1];
						r = q;
					end
				endcase
				g1p = gpol[0];
				rd(lcis_pkg::CTRL_OFFSET, 1'b0, ctrl | {25'h0, r, 6'h0});
			end
		end
		$display("test cell functions done");
		// cell off must force a low output whatever the gates say
		apb(1'b1, lcis_pkg::CTRL_OFFSET, ctrl & 32'hFFFF_7FFF);
		repeat (6) @(posedge pclk);
		rd(lcis_pkg::CTRL_OFFSET, 1'b0, ctrl & 32'hFFFF_7FFF);
		$display("test cell off done");
		repeat (4) @(posedge pclk);
		tally_and_finish();
	end
endmodule
